// >>> verilog/ccl_comparator_ctrl.sv
`timescale 1ns/100ps
`default_nettype none

module ccl_comparator_ctrl
   import ccl_pkg::*;
#(
   parameter int VOLT_W = 10
) (
   // Clock and reset
   input  wire logic                  i_clock,
   input  wire logic                  i_rst,
   // Avalon-MM slave
   input  wire logic [9:0]            i_avs_address,
   input  wire logic                  i_avs_read,
   input  wire logic                  i_avs_write,
   input  wire logic [3:0]            i_avs_byteenable,
   input  wire logic [31:0]           i_avs_writedata,
   output logic      [31:0]           o_avs_readdata,
   output logic                       o_avs_waitrequest,
   // Analog levels
   input  wire logic [VOLT_W-1:0]     i_positive_pin,
   input  wire logic [VOLT_W-1:0]     i_negative_pin,
   input  wire logic [VOLT_W-1:0]     i_bandgap_level,
   input  wire logic [8*VOLT_W-1:0]   i_converter_channel_pins,
   // Digital pin inputs
   input  wire logic                  i_pos_pin_digital,
   input  wire logic                  i_neg_pin_digital,
   // Interrupt
   input  wire logic                  i_global_irq_enable,
   input  wire logic                  i_irq_vector_taken,
   output logic                       o_compare_irq,
   // Comparator and pin control
   output logic                       o_comparator_power_off,
   output logic                       o_capture_input,
   output logic                       o_pos_pin_input_off,
   output logic                       o_neg_pin_input_off,
   output logic                       o_pos_pin_port_bit,
   output logic                       o_neg_pin_port_bit,
   output logic [2:0]                 o_trigger_source
);

   // ----------------------------------------
   // Register state
   // ----------------------------------------
   logic                power_off_q;
   logic                bandgap_select_q;
   logic                event_flag_q;
   logic                event_flag_d;
   logic                irq_enable_q;
   logic                capture_route_q;
   logic [1:0]          irq_mode_q;
   logic                neg_mux_enable_q;
   logic [2:0]          trigger_source_q;
   logic                neg_pin_off_q;
   logic                pos_pin_off_q;
   logic                converter_enable_q;
   logic [2:0]          channel_select_q;

   // ----------------------------------------
   // Bus handshake
   // ----------------------------------------
   logic                wait_q;
   logic [31:0]         rdata_q;
   logic [31:0]         rdata_d;
   logic [7:0]          reg_index;
   wire                 bus_req    = i_avs_read | i_avs_write;
   wire                 bus_accept = bus_req & ~wait_q;
   wire                 wr_commit  = bus_accept & i_avs_write
                                     & i_avs_byteenable[0];
   wire  [7:0]          wbyte      = i_avs_writedata[7:0];

   assign reg_index = i_avs_address[9:2];

   wire hit_ctrl = reg_index == CCL_IDX_CTRL_STATUS;
   wire hit_cvb  = reg_index == CCL_IDX_CONV_CTRL_B;
   wire hit_pin  = reg_index == CCL_IDX_PIN_DISABLE;
   wire hit_neg  = reg_index == CCL_IDX_NEG_SELECT;

   wire wr_ctrl  = wr_commit & hit_ctrl;
   wire wr_cvb   = wr_commit & hit_cvb;
   wire wr_pin   = wr_commit & hit_pin;
   wire wr_neg   = wr_commit & hit_neg;

   // ----------------------------------------
   // Input selection
   // ----------------------------------------
   logic [VOLT_W-1:0]   chan_level;
   logic [VOLT_W-1:0]   pos_level;
   logic [VOLT_W-1:0]   neg_level;
   logic                use_channel;
   logic                raw_result;

   assign chan_level  = i_converter_channel_pins[
                        channel_select_q*VOLT_W +: VOLT_W];
   assign use_channel = neg_mux_enable_q & ~converter_enable_q;
   assign neg_level   = use_channel ? chan_level
                                    : i_negative_pin;
   assign pos_level   = bandgap_select_q ? i_bandgap_level
                                         : i_positive_pin;

   // Powered-off comparator yields zero
   assign raw_result  = ~power_off_q
                        & (pos_level > neg_level);

   // ----------------------------------------
   // Synchroniser and edge detect
   // ----------------------------------------
   logic                sync_a_q;
   logic                result_q;
   logic                result_prev_q;
   logic                rise_evt;
   logic                fall_evt;
   logic                mode_evt;

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         sync_a_q      <= 1'b0;
         result_q      <= 1'b0;
         result_prev_q <= 1'b0;
      end else begin
         sync_a_q      <= raw_result;
         result_q      <= sync_a_q;
         result_prev_q <= result_q;
      end
   end

   assign rise_evt = result_q & ~result_prev_q;
   assign fall_evt = ~result_q & result_prev_q;

   always_comb begin
      unique case (ccl_mode_e'(irq_mode_q))
         CCL_MODE_TOGGLE:   mode_evt = rise_evt | fall_evt;
         CCL_MODE_RESERVED: mode_evt = 1'b0;
         CCL_MODE_FALLING:  mode_evt = fall_evt;
         CCL_MODE_RISING:   mode_evt = rise_evt;
      endcase
   end

   // ----------------------------------------
   // Event flag
   // ----------------------------------------
   wire flag_clear = i_irq_vector_taken
                     | (wr_ctrl & wbyte[CCL_BIT_EVENT_FLAG]);

   // Set wins over a simultaneous clear
   assign event_flag_d = mode_evt | (event_flag_q & ~flag_clear);

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         event_flag_q <= 1'b0;
      end else begin
         event_flag_q <= event_flag_d;
      end
   end

   // ----------------------------------------
   // Control registers
   // ----------------------------------------
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         power_off_q      <= 1'b0;
         bandgap_select_q <= 1'b0;
         irq_enable_q     <= 1'b0;
         capture_route_q  <= 1'b0;
         irq_mode_q       <= CCL_RST_MODE;
      end else if (wr_ctrl) begin
         power_off_q      <= wbyte[CCL_BIT_POWER_OFF];
         bandgap_select_q <= wbyte[CCL_BIT_BANDGAP_SEL];
         irq_enable_q     <= wbyte[CCL_BIT_IRQ_ENABLE];
         capture_route_q  <= wbyte[CCL_BIT_CAPTURE_ROUTE];
         irq_mode_q       <= wbyte[CCL_BIT_MODE_HI:CCL_BIT_MODE_LO];
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         neg_mux_enable_q <= 1'b0;
         trigger_source_q <= CCL_RST_3BIT;
      end else if (wr_cvb) begin
         neg_mux_enable_q <= wbyte[CCL_BIT_NEG_MUX_EN];
         trigger_source_q <= wbyte[CCL_BIT_TRIG_SRC_HI:0];
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         neg_pin_off_q <= 1'b0;
         pos_pin_off_q <= 1'b0;
      end else if (wr_pin) begin
         neg_pin_off_q <= wbyte[CCL_BIT_NEG_PIN_OFF];
         pos_pin_off_q <= wbyte[CCL_BIT_POS_PIN_OFF];
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         converter_enable_q <= 1'b0;
         channel_select_q   <= CCL_RST_3BIT;
      end else if (wr_neg) begin
         converter_enable_q <= wbyte[CCL_BIT_CONV_ENABLE];
         channel_select_q   <= wbyte[CCL_BIT_CHAN_HI:0];
      end
   end

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   wire [7:0] ctrl_view = {power_off_q, bandgap_select_q, result_q,
                           event_flag_q, irq_enable_q, capture_route_q,
                           irq_mode_q};
   wire [7:0] cvb_view  = {1'b0, neg_mux_enable_q, 3'h0,
                           trigger_source_q};
   wire [7:0] pin_view  = {6'h00, neg_pin_off_q, pos_pin_off_q};
   wire [7:0] neg_view  = {4'h0, converter_enable_q,
                           channel_select_q};

   always_comb begin
      rdata_d = 32'h0000_0000;
      if (hit_ctrl) begin
         rdata_d[7:0] = ctrl_view;
      end else if (hit_cvb) begin
         rdata_d[7:0] = cvb_view;
      end else if (hit_pin) begin
         rdata_d[7:0] = pin_view;
      end else if (hit_neg) begin
         rdata_d[7:0] = neg_view;
      end
   end

   // One wait cycle, then the transfer completes
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         wait_q  <= 1'b1;
         rdata_q <= 32'h0000_0000;
      end else begin
         wait_q  <= ~(bus_req & wait_q);
         if (bus_req & wait_q & i_avs_read) begin
            rdata_q <= rdata_d;
         end
      end
   end

   assign o_avs_waitrequest = wait_q;
   assign o_avs_readdata    = rdata_q;

   // ----------------------------------------
   // Registered outputs
   // ----------------------------------------
   logic irq_q;
   logic capture_q;
   logic pos_port_q;
   logic neg_port_q;

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         irq_q      <= 1'b0;
         capture_q  <= 1'b0;
         pos_port_q <= 1'b0;
         neg_port_q <= 1'b0;
      end else begin
         irq_q      <= event_flag_q & irq_enable_q
                       & i_global_irq_enable;
         capture_q  <= capture_route_q & result_q;
         pos_port_q <= i_pos_pin_digital & ~pos_pin_off_q;
         neg_port_q <= i_neg_pin_digital & ~neg_pin_off_q;
      end
   end

   assign o_compare_irq          = irq_q;
   assign o_capture_input        = capture_q;
   assign o_pos_pin_port_bit     = pos_port_q;
   assign o_neg_pin_port_bit     = neg_port_q;
   assign o_comparator_power_off = power_off_q;
   assign o_pos_pin_input_off    = pos_pin_off_q;
   assign o_neg_pin_input_off    = neg_pin_off_q;
   assign o_trigger_source       = trigger_source_q;

endmodule : ccl_comparator_ctrl

`default_nettype wire

// >>> pkg/ccl_pkg.sv
package ccl_pkg;

   // ----------------------------------------
   // Register indices (byte address = 4 * index)
   // ----------------------------------------
   localparam logic [7:0] CCL_IDX_CTRL_STATUS  = 8'h50;
   localparam logic [7:0] CCL_IDX_CONV_CTRL_B  = 8'h7b;
   localparam logic [7:0] CCL_IDX_PIN_DISABLE  = 8'h60;
   localparam logic [7:0] CCL_IDX_NEG_SELECT   = 8'h61;

   // ----------------------------------------
   // comparator_control_status fields
   // ----------------------------------------
   localparam int CCL_BIT_POWER_OFF     = 7;
   localparam int CCL_BIT_BANDGAP_SEL   = 6;
   localparam int CCL_BIT_RESULT        = 5;
   localparam int CCL_BIT_EVENT_FLAG    = 4;
   localparam int CCL_BIT_IRQ_ENABLE    = 3;
   localparam int CCL_BIT_CAPTURE_ROUTE = 2;
   localparam int CCL_BIT_MODE_HI       = 1;
   localparam int CCL_BIT_MODE_LO       = 0;

   // ----------------------------------------
   // Other register fields
   // ----------------------------------------
   localparam int CCL_BIT_NEG_MUX_EN    = 6;
   localparam int CCL_BIT_TRIG_SRC_HI   = 2;
   localparam int CCL_BIT_NEG_PIN_OFF   = 1;
   localparam int CCL_BIT_POS_PIN_OFF   = 0;
   localparam int CCL_BIT_CONV_ENABLE   = 3;
   localparam int CCL_BIT_CHAN_HI       = 2;

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [7:0] CCL_RST_REG   = 8'h00;
   localparam logic [1:0] CCL_RST_MODE  = 2'h0;
   localparam logic [2:0] CCL_RST_3BIT  = 3'h0;

   // ----------------------------------------
   // Interrupt modes
   // ----------------------------------------
   typedef enum logic [1:0] {
      CCL_MODE_TOGGLE   = 2'b00,
      CCL_MODE_RESERVED = 2'b01,
      CCL_MODE_FALLING  = 2'b10,
      CCL_MODE_RISING   = 2'b11
   } ccl_mode_e;

endpackage : ccl_pkg

// >>> test/ccl_comparator_ctrl_chk.sv
`timescale 1ns/100ps
`default_nettype none
module ccl_comparator_ctrl_chk
   import ccl_pkg::*;
(
   // Bus
   input wire logic        i_clock,
   input wire logic        i_rst,
   input wire logic [9:0]  i_avs_address,
   input wire logic        i_avs_read,
   input wire logic        i_avs_write,
   input wire logic [31:0] o_avs_readdata,
   input wire logic        o_avs_waitrequest,
   // Pins and status
   input wire logic        i_pos_pin_digital,
   input wire logic        i_global_irq_enable,
   input wire logic        o_compare_irq,
   input wire logic        o_comparator_power_off,
   input wire logic        o_pos_pin_input_off,
   input wire logic        o_pos_pin_port_bit,
   input wire logic [2:0]  o_trigger_source
);
   // ---
   // Properties
   // ---
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);
   wire logic [7:0] idx     = i_avs_address[9:2];
   wire logic       rd_done = i_avs_read && !o_avs_waitrequest;
   wire logic       wr_done = i_avs_write && !o_avs_waitrequest;
   wire logic       wr_ctrl = wr_done && idx == CCL_IDX_CTRL_STATUS;
   wire logic       wr_ctlb = wr_done && idx == CCL_IDX_CONV_CTRL_B;
   sequence s_req; (i_avs_read || i_avs_write) && o_avs_waitrequest; endsequence
   sequence s_ans; !o_avs_waitrequest ##1 o_avs_waitrequest; endsequence
   property p_answer; s_req |=> s_ans; endproperty
   property p_quiet; !(i_avs_read || i_avs_write) |=> o_avs_waitrequest; endproperty
   property p_dis_read; rd_done && idx == CCL_IDX_PIN_DISABLE |-> o_avs_readdata[31:2] == 30'h0; endproperty
   property p_ctlb_read;
      rd_done && idx == CCL_IDX_CONV_CTRL_B |-> o_avs_readdata[31:7] == 25'h0 && o_avs_readdata[5:3] == 3'h0;
   endproperty
   property p_pwr; $changed(o_comparator_power_off) |-> $past(wr_ctrl); endproperty
   property p_trig; $changed(o_trigger_source) |-> $past(wr_ctlb); endproperty
   property p_irq; o_compare_irq |-> $past(i_global_irq_enable); endproperty
   property p_pos;
      !$past(i_rst) |-> o_pos_pin_port_bit == ($past(i_pos_pin_digital) && !$past(o_pos_pin_input_off));
   endproperty
   a_answer: assert property (p_answer) else $error("bus answer not one cycle");
   a_quiet: assert property (p_quiet) else $error("answer without request");
   a_dis_read: assert property (p_dis_read) else $error("disable reg upper bits set");
   a_ctlb_read: assert property (p_ctlb_read) else $error("control b fixed bits set");
   a_pwr: assert property (p_pwr) else $error("power off changed without write");
   a_trig: assert property (p_trig) else $error("trigger bits changed without write");
   a_irq: assert property (p_irq) else $error("irq without global enable");
   a_pos: assert property (p_pos) else $error("port bit wrong");
endmodule : ccl_comparator_ctrl_chk

bind ccl_comparator_ctrl ccl_comparator_ctrl_chk u_chk (
   .i_clock, .i_rst, .i_avs_address, .i_avs_read, .i_avs_write, .o_avs_readdata, .o_avs_waitrequest,
   .i_pos_pin_digital, .i_global_irq_enable, .o_compare_irq, .o_comparator_power_off, .o_pos_pin_input_off,
   .o_pos_pin_port_bit, .o_trigger_source);
`default_nettype wire

// >>> test/ccl_analog_src.sv
`timescale 1ns/100ps
`default_nettype none
module ccl_analog_src #(
   parameter int VOLT_W = 10
) (
   // Levels from the bench
   input  wire logic [VOLT_W-1:0]   i_pos_lvl,
   input  wire logic [VOLT_W-1:0]   i_neg_lvl,
   input  wire logic [8*VOLT_W-1:0] i_chan_lvl,
   // Pins toward the block
   output logic      [VOLT_W-1:0]   o_positive_pin,
   output logic      [VOLT_W-1:0]   o_negative_pin,
   output logic      [8*VOLT_W-1:0] o_converter_channel_pins,
   output logic                     o_pos_pin_digital,
   output logic                     o_neg_pin_digital
);
   // ---
   // Pins and digital buffers, high at or above mid scale
   // ---
   assign o_positive_pin           = i_pos_lvl;
   assign o_negative_pin           = i_neg_lvl;
   assign o_converter_channel_pins = i_chan_lvl;
   assign o_pos_pin_digital        = i_pos_lvl[VOLT_W-1];
   assign o_neg_pin_digital        = i_neg_lvl[VOLT_W-1];
endmodule : ccl_analog_src
`default_nettype wire

// >>> test/ccl_comparator_ctrl_test.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
   $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module ccl_comparator_ctrl_test
   import ccl_pkg::*;
;
   logic        clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, gie = 1'b0, vec = 1'b0;
   logic [3:0]  be = 4'hf;
   logic [9:0]  addr = 10'h0, pos = 10'h200, neg = 10'h3ff, bg = 10'h0, pp, np;
   logic [31:0] wdat = 32'h0, rdat, q, r;
   logic        wreq, irq, pwr, cap, poff, noff, pbit, nbit, pdig, ndig;
   logic [2:0]  trig;
   logic [79:0] chan = 80'h0, cp;
   logic [7:0]  ix [4] = '{CCL_IDX_CTRL_STATUS, CCL_IDX_CONV_CTRL_B, CCL_IDX_PIN_DISABLE, 8'h10};
   logic [7:0]  ex [4] = '{8'h00, 8'h47, 8'h03, 8'h00};
   int          n_fail = 0, cmp_count = 0, i, m, seed = 32'he531;

   ccl_analog_src u_src (.i_pos_lvl(pos), .i_neg_lvl(neg), .i_chan_lvl(chan), .o_positive_pin(pp),
      .o_negative_pin(np), .o_converter_channel_pins(cp), .o_pos_pin_digital(pdig), .o_neg_pin_digital(ndig));
   ccl_comparator_ctrl dut (.i_clock(clk), .i_rst(rst), .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
      .i_avs_byteenable(be), .i_avs_writedata(wdat), .o_avs_readdata(rdat), .o_avs_waitrequest(wreq),
      .i_positive_pin(pp), .i_negative_pin(np), .i_bandgap_level(bg), .i_converter_channel_pins(cp),
      .i_pos_pin_digital(pdig), .i_neg_pin_digital(ndig), .i_global_irq_enable(gie), .i_irq_vector_taken(vec),
      .o_compare_irq(irq), .o_comparator_power_off(pwr), .o_capture_input(cap), .o_pos_pin_input_off(poff),
      .o_neg_pin_input_off(noff), .o_pos_pin_port_bit(pbit), .o_neg_pin_port_bit(nbit), .o_trigger_source(trig));

   always #20 clk = ~clk;

   // ---
   // Bus, expectation and verdict
   // ---
   task automatic bus(input logic w, input logic [7:0] id, input logic [7:0] d, output logic [31:0] qo);
      @(posedge clk);
      addr <= {id, 2'b00};
      wdat <= {24'h0, d};
      rd <= !w;
      wr <= w;
      repeat (20) begin
         @(posedge clk);
         if (wreq === 1'b0) break;
      end
      if (wreq !== 1'b0) begin
         n_fail++;
         wrap_up();
      end
      // Completion edge: take data and release here
      qo = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask : bus

   function automatic logic exp_res(logic off, logic bgs, logic mx, logic cen, logic [2:0] ch);
      logic [9:0] p, n;
      p = bgs ? bg : pos;
      n = (mx && !cen) ? chan[ch*10 +: 10] : neg;
      return !off && (p > n);
   endfunction : exp_res

   task automatic wrap_up();
      $display("Counts: %0d compares, %0d mismatches", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : wrap_up

   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      for (i = 0; i < 4; i++) begin
         bus(1'b0, ix[i], 8'h0, q);
         `CHK("reset", 32'h0, q)
      end
      for (i = 1; i < 4; i++) begin
         bus(1'b1, ix[i], 8'hff, q);
         bus(1'b0, ix[i], 8'h0, q);
         `CHK("readback", {24'h0, ex[i]}, q)
      end
      `CHK("trigger", 3'h7, trig)
      `CHK("pos_off", 2'h3, {poff, noff})
      `CHK("port_bits", 2'h0, {pbit, nbit})
      be <= 4'he;
      bus(1'b1, CCL_IDX_PIN_DISABLE, 8'h00, q);
      be <= 4'hf;
      bus(1'b0, CCL_IDX_PIN_DISABLE, 8'h00, q);
      `CHK("lane_masked", 32'h3, q)
      bus(1'b1, CCL_IDX_PIN_DISABLE, 8'h00, q);
      repeat (2) @(posedge clk);
      `CHK("port_on", 1'b1, pbit)
      `CHK("neg_port_on", 1'b1, nbit)
      $display("test registers done");
      for (i = 0; i < 24; i++) begin
         r = $random(seed);
         pos <= r[9:0];
         neg <= r[19:10];
         bg <= r[29:20];
         chan <= 80'({$random(seed), $random(seed), $random(seed)});
         r = $random(seed);
         bus(1'b1, CCL_IDX_NEG_SELECT, {4'h0, r[3:0]}, q);
         bus(1'b1, CCL_IDX_CONV_CTRL_B, {1'b0, r[4], 6'h0}, q);
         bus(1'b1, CCL_IDX_CTRL_STATUS, {r[5], r[6], 6'h10}, q);
         repeat (3) @(posedge clk);
         bus(1'b0, CCL_IDX_CTRL_STATUS, 8'h0, q);
         `CHK("result", exp_res(r[5], r[6], r[4], r[3], r[2:0]), q[5])
         `CHK("power_off", r[5], pwr)
      end
      bus(1'b1, CCL_IDX_CONV_CTRL_B, 8'h0, q);
      // Power on, pin input, so no stale edge enters the mode test
      bus(1'b1, CCL_IDX_CTRL_STATUS, 8'h10, q);
      $display("test comparator done");
      for (m = 0; m < 4; m++) begin
         pos <= 10'h100;
         neg <= 10'h200;
         repeat (5) @(posedge clk);
         bus(1'b1, CCL_IDX_CTRL_STATUS, 8'h14 | m[7:0], q);
         pos <= 10'h300;
         repeat (5) @(posedge clk);
         `CHK("capture", 1'b1, cap)
         bus(1'b0, CCL_IDX_CTRL_STATUS, 8'h0, q);
         `CHK("rise_flag", m == 0 || m == 3, q[4])
         bus(1'b1, CCL_IDX_CTRL_STATUS, 8'h14 | m[7:0], q);
         pos <= 10'h100;
         repeat (5) @(posedge clk);
         bus(1'b0, CCL_IDX_CTRL_STATUS, 8'h0, q);
         `CHK("fall_flag", m == 0 || m == 2, q[4])
      end
      $display("test modes done");
      bus(1'b1, CCL_IDX_CTRL_STATUS, 8'h13, q);
      bus(1'b1, CCL_IDX_CTRL_STATUS, 8'h0b, q);
      pos <= 10'h300;
      repeat (5) @(posedge clk);
      `CHK("irq_masked", 1'b0, irq)
      `CHK("capture_off", 1'b0, cap)
      bus(1'b1, CCL_IDX_CTRL_STATUS, 8'h0b, q);
      bus(1'b0, CCL_IDX_CTRL_STATUS, 8'h0, q);
      `CHK("flag_kept", 32'h3b, q)
      gie <= 1'b1;
      repeat (2) @(posedge clk);
      `CHK("irq_on", 1'b1, irq)
      vec <= 1'b1;
      @(posedge clk);
      vec <= 1'b0;
      repeat (2) @(posedge clk);
      `CHK("irq_off", 1'b0, irq)
      bus(1'b0, CCL_IDX_CTRL_STATUS, 8'h0, q);
      `CHK("flag_gone", 32'h2b, q)
      $display("test interrupt done");
      wrap_up();
   end
endmodule : ccl_comparator_ctrl_test
`default_nettype wire
